// ### design/see_eeprom.sv
// two-wire serial eeprom target, write path, with a page buffer and array
// assumes scl and sda arrive asynchronously and that sda is wired-and outside
`timescale 1ns/1ps
module see_eeprom #(
    parameter int ADDR_W    = 13,
    parameter int PROG_CNT  = see_pkg::PROG_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        strap_select_bit0,
    input  wire logic        strap_select_bit1,
    input  wire logic        strap_select_bit2,
    input  wire logic        write_protect,
    output logic             prog_busy,
    output logic             standby
);
    localparam int MEM_BYTES = 1 << ADDR_W;
    localparam logic [ADDR_W-1:0] ADDR_RESET_W = see_pkg::ADDR_RESET[ADDR_W-1:0];

    // two-flop synchronisers, stage one read only by stage two
    logic [1:0] scl_sync_reg, sda_sync_reg;
    logic [4:0] pin_sync1_reg, pin_sync2_reg;
    logic       scl_q_reg, sda_q_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_sync_reg  <= 2'h3;
            sda_sync_reg  <= 2'h3;
            pin_sync1_reg <= 5'h00;
            pin_sync2_reg <= 5'h00;
            scl_q_reg     <= 1'b1;
            sda_q_reg     <= 1'b1;
        end else begin
            scl_sync_reg  <= {scl_sync_reg[0], scl_in};
            sda_sync_reg  <= {sda_sync_reg[0], sda_in};
            pin_sync1_reg <= {write_protect, strap_select_bit2, strap_select_bit1, strap_select_bit0, 1'b0};
            pin_sync2_reg <= pin_sync1_reg;
            scl_q_reg     <= scl_sync_reg[1];
            sda_q_reg     <= sda_sync_reg[1];
        end
    end

    // bus edge and condition decode
    wire       scl_s    = scl_sync_reg[1];
    wire       sda_s    = sda_sync_reg[1];
    wire       scl_rise = scl_s & ~scl_q_reg;
    wire       scl_fall = ~scl_s & scl_q_reg;
    wire       start_c  = scl_s & scl_q_reg & sda_q_reg & ~sda_s; // R05 R06
    wire       stop_c   = scl_s & scl_q_reg & ~sda_q_reg & sda_s; // R05 R07
    wire [2:0] straps   = pin_sync2_reg[3:1]; // R02 straps pulled down outside
    wire       wp_s     = pin_sync2_reg[4];

    see_pkg::see_state_e state_reg, state_next;
    logic [3:0]        bit_cnt_reg;
    logic [7:0]        shift_reg;
    logic [1:0]        phase_reg;
    logic              ack_ok_reg, wr_sel_reg, pending_reg, drive_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0]        page_buf [see_pkg::PAGE_BYTES];
    logic [see_pkg::PAGE_BYTES-1:0] page_valid_reg;
    logic [7:0]        mem [MEM_BYTES];
    logic [31:0]       prog_cnt_reg;
    logic [5:0]        commit_idx_reg;

    wire [7:0] rx_byte   = {shift_reg[6:0], sda_s};
    wire       dev_match = (rx_byte[7:4] == see_pkg::DEV_TYPE_CODE) & (rx_byte[3:1] == straps); // R11 R12
    wire       byte_done = scl_fall & (bit_cnt_reg == see_pkg::BIT_CNT_ACK);
    wire       prog_done = (prog_cnt_reg == 32'(PROG_CNT - 1));
    wire       prog_go   = stop_c & pending_reg & ~wp_s; // R16 R25
    wire [4:0] low_next  = addr_reg[4:0] + 5'h01; // R19
    wire       byte_cap  = scl_rise & (state_reg == see_pkg::SEE_RX_BITS) & (bit_cnt_reg == 4'h7); // eighth bit sampled

    // bus state sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            see_pkg::SEE_STANDBY: begin
                if (start_c) state_next = see_pkg::SEE_RX_BITS; // R06 R09
            end
            see_pkg::SEE_IGNORE: begin
                if (start_c) state_next = see_pkg::SEE_RX_BITS; // R09
                else if (stop_c) state_next = see_pkg::SEE_STANDBY; // R10 stop after an ignored frame
            end
            see_pkg::SEE_RX_BITS: begin
                if (start_c) state_next = see_pkg::SEE_RX_BITS; // R09
                else if (prog_go) state_next = see_pkg::SEE_PROGRAM; // R16
                else if (stop_c) state_next = see_pkg::SEE_STANDBY; // R07 R10
                else if (byte_done) state_next = ack_ok_reg ? see_pkg::SEE_ACK : see_pkg::SEE_IGNORE;
            end
            see_pkg::SEE_ACK: begin
                // reads are not served: after the read address ack the bus is ignored
                if (scl_fall) state_next = wr_sel_reg ? see_pkg::SEE_RX_BITS : see_pkg::SEE_IGNORE; // R13
            end
            see_pkg::SEE_PROGRAM: begin
                if (prog_done) state_next = see_pkg::SEE_STANDBY; // R17 R10
            end
        endcase
    end

    // bit counter and shift register
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg   <= see_pkg::SEE_STANDBY; // R10
            bit_cnt_reg <= see_pkg::BIT_CNT_RESET;
            shift_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (start_c || state_next != see_pkg::SEE_RX_BITS) begin
                bit_cnt_reg <= see_pkg::BIT_CNT_RESET;
            end else if (scl_rise && state_reg == see_pkg::SEE_RX_BITS) begin
                shift_reg   <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // decode of each received byte: address, pointer, page data
    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_reg      <= see_pkg::PHASE_DEV;
            ack_ok_reg     <= 1'b0;
            wr_sel_reg     <= 1'b0;
            pending_reg    <= 1'b0;
            addr_reg       <= ADDR_RESET_W;
            page_valid_reg <= '0;
        end else if (state_reg == see_pkg::SEE_PROGRAM) begin
            pending_reg    <= 1'b0;
            phase_reg      <= see_pkg::PHASE_DEV;
            if (prog_done) page_valid_reg <= '0;
        end else if (start_c) begin
            phase_reg      <= see_pkg::PHASE_DEV; // R09
            pending_reg    <= 1'b0;
            page_valid_reg <= '0;
        end else if (stop_c) begin
            phase_reg <= see_pkg::PHASE_DEV;
            if (!prog_go) page_valid_reg <= '0; // R25 protected data dropped
        end else if (byte_cap) begin
            unique case (phase_reg)
                see_pkg::PHASE_DEV: begin
                    ack_ok_reg <= dev_match; // R14 R23 busy state never reaches here
                    wr_sel_reg <= ~sda_s; // R13
                    phase_reg  <= (dev_match & ~sda_s) ? see_pkg::PHASE_ADDR_HI : see_pkg::PHASE_DEV;
                end
                see_pkg::PHASE_ADDR_HI: begin
                    addr_reg[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0]; // R15 R24
                    phase_reg <= see_pkg::PHASE_ADDR_LO;
                end
                see_pkg::PHASE_ADDR_LO: begin
                    addr_reg[7:0] <= rx_byte; // R15
                    phase_reg <= see_pkg::PHASE_DATA;
                end
                see_pkg::PHASE_DATA: begin
                    page_valid_reg[addr_reg[4:0]] <= 1'b1; // R20 later bytes replace earlier
                    addr_reg[4:0] <= low_next; // R19 R20 upper bits held
                    pending_reg   <= 1'b1; // R18
                end
            endcase
        end
    end

    // page buffer capture
    always_ff @(posedge mclk) begin
        if (byte_cap && phase_reg == see_pkg::PHASE_DATA) begin
            page_buf[addr_reg[4:0]] <= rx_byte; // R22
        end
    end

    // self-timed programming; whole page written within the cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            prog_cnt_reg   <= 32'h0;
            commit_idx_reg <= 6'h00;
        end else if (state_reg == see_pkg::SEE_PROGRAM) begin
            prog_cnt_reg <= prog_cnt_reg + 32'h1; // R17
            if (commit_idx_reg < 6'(see_pkg::PAGE_BYTES)) commit_idx_reg <= commit_idx_reg + 6'h01;
        end else begin
            prog_cnt_reg   <= 32'h0;
            commit_idx_reg <= 6'h00;
        end
    end

    // array write of buffered bytes, write protect blocks everything
    wire [4:0] cidx = commit_idx_reg[4:0];
    always_ff @(posedge mclk) begin
        if (state_reg == see_pkg::SEE_PROGRAM && !commit_idx_reg[5] && page_valid_reg[cidx] && !wp_s) begin
            mem[{addr_reg[ADDR_W-1:5], cidx}] <= page_buf[cidx]; // R21 R03
        end
    end

    // acknowledge drive: low or released only
    always_ff @(posedge mclk) begin
        if (rst) drive_reg <= 1'b0;
        else drive_reg <= (state_next == see_pkg::SEE_ACK); // R08 R14 R18
    end
    assign sda_out   = 1'b0; // R01
    assign sda_oe    = drive_reg; // R01
    assign prog_busy = (state_reg == see_pkg::SEE_PROGRAM);
    assign standby   = (state_reg == see_pkg::SEE_STANDBY);

    // ack of every byte in a matched write frame is seen two cycles after its eighth clock falls
    sequence s_byte_end;
        byte_done && ack_ok_reg && state_reg == see_pkg::SEE_RX_BITS;
    endsequence
    chk_ack_drive_after: assert property (@(posedge mclk) disable iff (rst) // R08
        s_byte_end |=> ##1 sda_oe) else $error("ack not driven");
    chk_sda_low_only: assert property (@(posedge mclk) disable iff (rst) // R01
        sda_oe |-> !sda_out) else $error("sda driven high");
    chk_start_resets: assert property (@(posedge mclk) disable iff (rst) // R09
        (start_c && state_reg != see_pkg::SEE_PROGRAM) |=> state_reg == see_pkg::SEE_RX_BITS && bit_cnt_reg == 4'h0)
        else $error("start did not reset");
    chk_busy_no_ack: assert property (@(posedge mclk) disable iff (rst) // R16
        prog_busy |-> !sda_oe) else $error("ack while programming");
    chk_prog_ends: assert property (@(posedge mclk) disable iff (rst) // R17
        (prog_busy && prog_done) |=> standby) else $error("programming did not end");
    chk_wp_no_prog: assert property (@(posedge mclk) disable iff (rst) // R25
        (stop_c && wp_s && state_reg == see_pkg::SEE_RX_BITS) |=> !prog_busy)
        else $error("protected write programmed");
    chk_stop_prog: assert property (@(posedge mclk) disable iff (rst) // R16
        (stop_c && pending_reg && !wp_s && state_reg == see_pkg::SEE_RX_BITS) |=> prog_busy)
        else $error("no program");
    chk_page_wrap: assert property (@(posedge mclk) disable iff (rst) // R19
        (phase_reg == see_pkg::PHASE_DATA && !prog_busy) |=> addr_reg[ADDR_W-1:5] == $past(addr_reg[ADDR_W-1:5]))
        else $error("upper address moved");
    chk_mismatch_idle: assert property (@(posedge mclk) disable iff (rst) // R11
        (byte_done && !ack_ok_reg && state_reg == see_pkg::SEE_RX_BITS) |=> state_reg == see_pkg::SEE_IGNORE)
        else $error("mismatch not ignored");

    // named steps of a transfer, shared by the properties below
    sequence s_start_seen;
        start_c && state_reg != see_pkg::SEE_PROGRAM;
    endsequence
    sequence s_stop_no_write;
        stop_c && (!pending_reg || wp_s) && state_reg != see_pkg::SEE_PROGRAM && state_reg != see_pkg::SEE_ACK;
    endsequence
    sequence s_ack_clock_end;
        state_reg == see_pkg::SEE_ACK && scl_fall;
    endsequence
    sequence s_addr_lo_cap;
        byte_cap && phase_reg == see_pkg::PHASE_ADDR_LO;
    endsequence
    sequence s_data_cap;
        byte_cap && phase_reg == see_pkg::PHASE_DATA;
    endsequence

    // cycles spent in one programming run, counted apart from the timer
    logic [31:0] prog_run_reg;
    always_ff @(posedge mclk) begin
        if (rst) prog_run_reg <= 32'h0;
        else if (prog_busy) prog_run_reg <= prog_run_reg + 32'h1;
        else prog_run_reg <= 32'h0;
    end

    // acknowledge timing, release and refusal
    chk_ack_release: assert property (@(posedge mclk) disable iff (rst) // R08
        s_ack_clock_end |=> !sda_oe)
        else $error("ack held past ninth clock");
    chk_ack_in_slot: assert property (@(posedge mclk) disable iff (rst) // R14
        sda_oe |-> state_reg == see_pkg::SEE_ACK)
        else $error("data pulled low outside ack slot");
    chk_ignore_quiet: assert property (@(posedge mclk) disable iff (rst) // R11
        state_reg == see_pkg::SEE_IGNORE |-> !sda_oe)
        else $error("ignored frame acknowledged");
    chk_read_dropped: assert property (@(posedge mclk) disable iff (rst) // R13
        (state_reg == see_pkg::SEE_ACK && scl_fall && !wr_sel_reg) |=> state_reg == see_pkg::SEE_IGNORE)
        else $error("read frame not ignored after address");

    // stop, start and programming handling
    chk_stop_standby: assert property (@(posedge mclk) disable iff (rst) // R10
        s_stop_no_write |=> standby)
        else $error("no standby after stop");
    chk_stop_clears_phase: assert property (@(posedge mclk) disable iff (rst) // R07
        (stop_c && state_reg != see_pkg::SEE_PROGRAM) |=> phase_reg == see_pkg::PHASE_DEV)
        else $error("stop left byte phase behind");
    chk_standby_quiet: assert property (@(posedge mclk) disable iff (rst) // R10
        standby |-> !sda_oe && !prog_busy)
        else $error("activity in standby");
    chk_start_clears: assert property (@(posedge mclk) disable iff (rst) // R09
        s_start_seen |=> !pending_reg && page_valid_reg == '0 && phase_reg == see_pkg::PHASE_DEV)
        else $error("start left transfer state behind");
    chk_busy_holds: assert property (@(posedge mclk) disable iff (rst) // R16
        (prog_busy && !prog_done) |=> prog_busy)
        else $error("programming cut short");
    chk_busy_bounded: assert property (@(posedge mclk) disable iff (rst) // R17
        prog_busy |-> prog_run_reg < 32'(PROG_CNT))
        else $error("programming overran");
    chk_commit_done: assert property (@(posedge mclk) disable iff (rst) // R21
        (prog_busy && prog_done) |-> commit_idx_reg == 6'(see_pkg::PAGE_BYTES))
        else $error("page not fully committed");

    // pointer load, data capture and in-page increment
    chk_pointer_load: assert property (@(posedge mclk) disable iff (rst) // R15
        s_addr_lo_cap |=> addr_reg[7:0] == $past(rx_byte))
        else $error("low address not loaded");
    chk_pending_data: assert property (@(posedge mclk) disable iff (rst) // R18
        s_data_cap |=> pending_reg)
        else $error("data byte not marked for programming");
    chk_wrap_step: assert property (@(posedge mclk) disable iff (rst) // R19 R20
        s_data_cap |=> addr_reg[4:0] == $past(addr_reg[4:0]) + 5'h01)
        else $error("page offset did not step");
    chk_bit_count: assert property (@(posedge mclk) disable iff (rst) // R08
        bit_cnt_reg <= see_pkg::BIT_CNT_ACK)
        else $error("bit count past eight");
endmodule

// ### design/see_pkg.sv
// constants for the two-wire serial eeprom target write path
// assumes a 125 MHz system clock that oversamples the bus lines
// Summary of operation
// R01 - data line only pulled low or released
// R02 - unconnected strap inputs read as zero
// R03 - write protect guards whole array or none
// R04 - controller makes clock, start and stop
// R05 - data change while clock high is condition
// R06 - falling data, clock high is start
// R07 - rising data, clock high is stop
// R08 - receiver acknowledges each byte by pulling low
// R09 - any start resets the interface state
// R10 - standby at power-up, idle stop, after write
// R11 - address byte upper nibble must be 1010
// R12 - next three bits match the strap inputs
// R13 - last address bit selects read or write
// R14 - acknowledge matching address on ninth clock
// R15 - two address bytes load the pointer
// R16 - stop starts programming, inputs then ignored
// R17 - programming self-timed, at most 5 ms
// R18 - page write takes 31 more bytes, acked
// R19 - only five low address bits increment
// R20 - beyond 32 bytes, wrap and overwrite
// R21 - whole page committed in one cycle
// R22 - 4K or 8K bytes in 32-byte pages
// R23 - busy device withholds write address acknowledge
// R24 - use only low 12 or 13 address bits
// R25 - protected write acked but never programmed
package see_pkg;
    localparam int          CLK_HZ         = 125_000_000;
    localparam int          PROG_TIME_US   = 5000;
    localparam int          PROG_CYCLES    = (PROG_TIME_US * (CLK_HZ / 1_000_000));
    localparam logic [3:0]  DEV_TYPE_CODE  = 4'ha;
    localparam int          PAGE_BYTES     = 32;
    localparam int          PAGE_BITS      = 5;
    localparam logic [3:0]  BIT_CNT_ACK    = 4'h8;
    localparam logic [3:0]  BIT_CNT_RESET  = 4'h0;
    localparam logic [12:0] ADDR_RESET     = 13'h0000;
    localparam logic [1:0]  PHASE_DEV      = 2'h0;
    localparam logic [1:0]  PHASE_ADDR_HI  = 2'h1;
    localparam logic [1:0]  PHASE_ADDR_LO  = 2'h2;
    localparam logic [1:0]  PHASE_DATA     = 2'h3;

    typedef enum logic [2:0] {
        SEE_STANDBY  = 3'b000,
        SEE_RX_BITS  = 3'b001,
        SEE_ACK      = 3'b010,
        SEE_IGNORE   = 3'b011,
        SEE_PROGRAM  = 3'b100
    } see_state_e;
endpackage

// ### verif/see_bus_host.sv
// bus controller model: makes the clock, start, stop and data bits
// assumes a pull-up outside resolves the data line from all pull-downs
`timescale 1ns/1ps
module see_bus_host (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_line
);
    localparam realtime QTR = 31.25; // quarter of the 125 ns link period
    // idle bus: clock parked high, data released, so no clock outside frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // data falls while clock high; also reopens a frame cut short
    task automatic start();
        sda_pull = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_pull = 1'b1;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    // one clock pulse; data set only while clock low, sampled mid-high
    task automatic send_bit(input logic b, output logic line);
        sda_pull = ~b;
        #QTR scl = 1'b1;
        #QTR line = sda_line;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    // eight bits msb first, then a released ninth bit for the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic l;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i], l);
        end
        send_bit(1'b1, l);
        ack = ~l;
    endtask
    // data rises while clock high
    task automatic stop();
        sda_pull = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_pull = 1'b0;
        #QTR;
    endtask
endmodule

// ### verif/see_eeprom_bench.sv
// self-checking bench for the eeprom target write path
// assumes the bus controller model drives the bus and a pull-up on data
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module see_eeprom_bench;
    localparam int PROG = 300; // shortened programming time
    logic       mclk, rst, scl, host_pull, sda_line, sda_out, sda_oe, wp, prog_busy, standby, a;
    logic [2:0] strap;
    int         bad_count, n_compared, cycles, busy_len, busy_run, busy_rises, acks, r0;
    // wired-and data line with pull-up
    assign sda_line = ~(host_pull | (sda_oe & ~sda_out));
    see_bus_host host (.scl(scl), .sda_pull(host_pull), .sda_line(sda_line));
    see_eeprom #(.ADDR_W(13), .PROG_CNT(PROG)) dut (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .strap_select_bit0(strap[0]), .strap_select_bit1(strap[1]), .strap_select_bit2(strap[2]),
        .write_protect(wp), .prog_busy(prog_busy), .standby(standby));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // programming length and count, timeout, open-drain watch
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        busy_run <= prog_busy ? busy_run + 1 : 0;
        if (prog_busy === 1'b1 && busy_run == 0) busy_rises <= busy_rises + 1;
        if (prog_busy !== 1'b1 && busy_run != 0) busy_len <= busy_run;
        if (sda_oe === 1'b1) `CHK(sda_out, 1'b0, "data driven high")
        if (cycles == 40000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic test_done();
        if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // write frame: device byte, two address bytes, n data bytes, stop
    task automatic frame(input logic [7:0] dev, input int n);
        acks = 0;
        r0 = busy_rises;
        host.start();
        host.send_byte(dev, a); acks += a;
        host.send_byte(8'he3, a); acks += a;
        host.send_byte(8'h7c, a); acks += a;
        for (int i = 0; i < n; i++) begin
            host.send_byte(8'h5a ^ i[7:0], a); acks += a;
        end
        host.stop();
    endtask
    // wait out any programming, then judge its count and length
    task automatic settle(input int progs);
        repeat (PROG + 60) @(posedge mclk);
        `CHK(busy_rises - r0, progs, "programming count")
        if (progs > 0) `CHK(busy_len inside {[PROG - 1:PROG + 1]}, 1'b1, "programming length")
        `CHK(standby, 1'b1, "standby after frame")
    endtask
    task automatic addr_only(input logic [7:0] dev, input logic exp);
        host.start();
        host.send_byte(dev, a);
        host.stop();
        `CHK(a, exp, "address acknowledge")
    endtask
    task automatic t_byte_write();
        frame(8'haa, 1);
        `CHK(acks, 4, "byte write acks")
        `CHK(prog_busy, 1'b1, "busy after stop")
        addr_only(8'haa, 1'b0);
        settle(1);
        `CHK(dut.mem[13'h037c], 8'h5a, "byte written at pointer")
    endtask
    task automatic t_page_write();
        frame(8'haa, 33);
        `CHK(acks, 36, "page write acks")
        settle(1);
        `CHK(dut.mem[13'h037c], 8'h7a, "33rd byte did not overwrite first")
        `CHK(dut.mem[13'h0360], 8'h5e, "offset did not wrap to page start")
    endtask
    task automatic t_addressing();
        for (int s = 0; s < 8; s++) begin
            addr_only({4'ha, s[2:0], 1'b0}, s[2:0] == strap);
        end
        addr_only({4'hb, strap, 1'b0}, 1'b0);
        `CHK(standby, 1'b1, "standby after ignored frame")
        addr_only({4'ha, strap, 1'b1}, 1'b1);
        host.start();
        host.send_byte({4'ha, strap, 1'b1}, a);
        host.send_byte({4'ha, strap, 1'b0}, a);
        host.stop();
        `CHK(a, 1'b0, "byte after read address acknowledged")
        r0 = busy_rises;
        settle(0);
    endtask
    task automatic t_protect();
        @(posedge mclk) #1 wp = 1'b1;
        frame(8'haa, 2);
        `CHK(acks, 5, "protected write acks")
        settle(0);
        `CHK(dut.mem[13'h037c], 8'h7a, "protected array changed")
        @(posedge mclk) #1 wp = 1'b0;
    endtask
    task automatic t_restart();
        r0 = busy_rises;
        host.start();
        host.send_byte(8'haa, a);
        host.send_byte(8'h01, a);
        host.send_byte(8'h02, a);
        host.send_byte(8'h11, a);
        host.send_bit(1'b0, a);
        host.send_bit(1'b1, a);
        host.start();
        host.send_byte(8'haa, a);
        `CHK(a, 1'b1, "ack after restart")
        host.stop();
        settle(0);
    endtask
    initial begin
        rst = 1'b1;
        wp = 1'b0;
        strap = 3'b101;
        {bad_count, n_compared, cycles, busy_len, busy_run, busy_rises} = '0;
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (2) @(posedge mclk);
        #1 `CHK({standby, prog_busy, sda_oe}, 3'b100, "reset outputs")
        strap = 3'b101;
        t_byte_write();
        @(posedge mclk) #1 strap = 3'b101;
        t_page_write();
        @(posedge mclk) #1 strap = 3'b011;
        t_addressing();
        @(posedge mclk) #1 strap = 3'b101;
        t_protect();
        t_restart();
        test_done();
    end
endmodule
